/* core/rsbx_map.vh */
// Register offsets, field positions, opcodes and timing counts of the return/skip/bit executor
`ifndef RSBX_MAP_VH
`define RSBX_MAP_VH

// Register byte offsets on the AXI4-Lite slave
`define RSBX_ADDR_INSTR 8'h00
`define RSBX_ADDR_W 8'h04
`define RSBX_ADDR_STATUS 8'h08
`define RSBX_ADDR_FSRPTR 8'h0c
`define RSBX_ADDR_PC 8'h10
`define RSBX_ADDR_TIMER 8'h14
`define RSBX_ADDR_STACK 8'h18
`define RSBX_ADDR_SHW 8'h1c
`define RSBX_ADDR_SHSTATUS 8'h20
`define RSBX_ADDR_SHPTR 8'h24
`define RSBX_ADDR_SHPC 8'h28
`define RSBX_ADDR_STATE 8'h2c
`define RSBX_ADDR_WAKE 8'h30
// File registers sit at 8'h80 + 4*index
`define RSBX_FILE_SEL_BIT 7

// Status bit positions
`define RSBX_ST_CARRY 0
`define RSBX_ST_HALFC 1
`define RSBX_ST_ZERO 2
`define RSBX_ST_PDOWN 3
`define RSBX_ST_TMOUT 4
// Timeout and power-down bits, kept across interrupt return
`define RSBX_ST_KEEP_MASK 8'h18

// File indices that alias core registers
`define RSBX_F_TIMER 5'h01
`define RSBX_F_STATUS 5'h03
`define RSBX_F_PTR 5'h04

// Opcodes
`define RSBX_OP_SLEEP 12'h003
`define RSBX_OP_RETURN 12'h00c
`define RSBX_OP_PRETURN 12'h00d
`define RSBX_OP_IRETURN 12'h00e
`define RSBX_OP_IRETURN_T 12'h00f
`define RSBX_OP_SKIP 12'h602
`define RSBX_OP_FORCE_C 12'h503
`define RSBX_OP_LITRET 4'h8
`define RSBX_OP_ROTL 7'h1b
`define RSBX_OP_ROTR 7'h19
`define RSBX_OP_TEST_ONE 4'h7
`define RSBX_OP_TEST_ZERO 4'h6
`define RSBX_OP_BITSET 4'h5

// Cycle counts
`define RSBX_CYC_RETURN 2'd3
`define RSBX_CYC_SINGLE 2'd1

// Reset values
`define RSBX_RST_STATUS 8'h18
`define RSBX_RST_PC 12'h000

// AXI responses
`define RSBX_RESP_OKAY 2'b00
`define RSBX_RESP_SLVERR 2'b10

`endif

/* core/rsbx_bit_alu.v */
// Rotate, bit-force and skip-decision logic for one instruction word
`timescale 1ns/10ps
`default_nettype none
`include "rsbx_map.vh"

module rsbx_bit_alu (
    input wire [11:0] opcode,
    input wire [7:0] fileVal,
    input wire carryIn,
    output reg [7:0] result,
    output reg carryOut,
    output reg fileWe,
    output reg carryWe,
    output reg skipOut
);
    reg [7:0] bitMask;

    always @* begin
        bitMask = 8'h01 << opcode[7:5];
        result = fileVal;
        carryOut = carryIn;
        fileWe = 1'b0;
        carryWe = 1'b0;
        skipOut = 1'b0;
        if (opcode == `RSBX_OP_FORCE_C) begin
            carryOut = 1'b1;
            carryWe = 1'b1;
        end else if (opcode == `RSBX_OP_SKIP) begin
            skipOut = 1'b1;
        end else if (opcode[11:5] == `RSBX_OP_ROTL) begin
            result = {fileVal[6:0], carryIn};
            carryOut = fileVal[7];
            fileWe = 1'b1;
            carryWe = 1'b1;
        end else if (opcode[11:5] == `RSBX_OP_ROTR) begin
            result = {carryIn, fileVal[7:1]};
            carryOut = fileVal[0];
            fileWe = 1'b1;
            carryWe = 1'b1;
        end else if (opcode[11:8] == `RSBX_OP_TEST_ONE) begin
            // Carry test is bit 0 of the status file
            skipOut = (fileVal & bitMask) != 8'h00;
        end else if (opcode[11:8] == `RSBX_OP_TEST_ZERO) begin
            skipOut = (fileVal & bitMask) == 8'h00;
        end else if (opcode[11:8] == `RSBX_OP_BITSET) begin
            result = fileVal | bitMask;
            fileWe = 1'b1;
        end
    end
endmodule // rsbx_bit_alu

`default_nettype wire

/* core/rsbx_exec.v */
// Return, skip and bit instruction executor with an AXI4-Lite register slave
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "rsbx_map.vh"

module rsbx_exec #(
    parameter LARGE_PAGE = 0
) (
    input wire clk,
    input wire rstn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg wdtClear_q,
    output reg oscStopped_q
);
    reg [7:0] w_q;
    reg [7:0] status_q;
    reg [7:0] ptr_q;
    reg [11:0] pc_q;
    reg [7:0] timer_q;
    reg [11:0] stackTop_q;
    reg [7:0] shW_q;
    reg [7:0] shStatus_q;
    reg [7:0] shPtr_q;
    reg [11:0] shPc_q;
    reg [7:0] fileMem_q [0:31];
    reg skip_q;
    reg [1:0] waitCnt_q;
    reg awHave_q;
    reg [7:0] awAddr_q;
    reg wHave_q;
    reg [31:0] wData_q;
    reg [3:0] wStrb_q;
    integer i;

    wire [7:0] fileView [0:31];
    wire [11:0] opcode = wData_q[11:0];
    wire [4:0] fileIdx = opcode[4:0];
    wire doWrite = awHave_q && wHave_q && (waitCnt_q == 2'd0) && !s_axi_bvalid;
    wire isInstr = (awAddr_q == `RSBX_ADDR_INSTR);
    wire [7:0] aluResult;
    wire aluCarry;
    wire aluFileWe;
    wire aluCarryWe;
    wire aluSkip;

    // Timer, status and pointer appear in the file space as in the core
    genvar g;
    generate
        for (g = 0; g < 32; g = g + 1) begin : gFileView
            assign fileView[g] = (g == `RSBX_F_TIMER) ? timer_q :
                                 (g == `RSBX_F_STATUS) ? status_q :
                                 (g == `RSBX_F_PTR) ? ptr_q : fileMem_q[g];
        end
    endgenerate

    rsbx_bit_alu uAlu (
        .opcode(opcode),
        .fileVal(fileView[fileIdx]),
        .carryIn(status_q[`RSBX_ST_CARRY]),
        .result(aluResult),
        .carryOut(aluCarry),
        .fileWe(aluFileWe),
        .carryWe(aluCarryWe),
        .skipOut(aluSkip)
    );

    // 12-bit registers take byte lanes 0 and 1 only
    function [11:0] applyStrb;
        input [11:0] oldV;
        input [31:0] newV;
        input [3:0] strb;
        begin
            applyStrb = oldV;
            if (strb[0]) begin
                applyStrb[7:0] = newV[7:0];
            end
            if (strb[1]) begin
                applyStrb[11:8] = newV[11:8];
            end
        end
    endfunction

    function isMapped;
        input [7:0] addr;
        begin
            isMapped = addr[`RSBX_FILE_SEL_BIT] || (addr[1:0] == 2'b00 && addr <= `RSBX_ADDR_WAKE);
        end
    endfunction

    // Page bits taken from the return address
    function [7:0] pagedStatus;
        input [7:0] st;
        input [11:0] retAddr;
        begin
            pagedStatus = st;
            if (LARGE_PAGE != 0) begin
                pagedStatus[7:5] = retAddr[11:9];
            end else begin
                pagedStatus[6:5] = retAddr[10:9];
            end
        end
    endfunction

    reg [31:0] rdMux;
    always @* begin
        rdMux = 32'h00000000;
        if (s_axi_araddr[`RSBX_FILE_SEL_BIT]) begin
            rdMux = {24'h000000, fileView[s_axi_araddr[6:2]]};
        end else begin
            case ({s_axi_araddr[7:2], 2'b00})
                `RSBX_ADDR_W: rdMux = {24'h000000, w_q};
                `RSBX_ADDR_STATUS: rdMux = {24'h000000, status_q};
                `RSBX_ADDR_FSRPTR: rdMux = {24'h000000, ptr_q};
                `RSBX_ADDR_PC: rdMux = {20'h00000, pc_q};
                `RSBX_ADDR_TIMER: rdMux = {24'h000000, timer_q};
                `RSBX_ADDR_STACK: rdMux = {20'h00000, stackTop_q};
                `RSBX_ADDR_SHW: rdMux = {24'h000000, shW_q};
                `RSBX_ADDR_SHSTATUS: rdMux = {24'h000000, shStatus_q};
                `RSBX_ADDR_SHPTR: rdMux = {24'h000000, shPtr_q};
                `RSBX_ADDR_SHPC: rdMux = {20'h00000, shPc_q};
                `RSBX_ADDR_STATE: rdMux = {29'h0, oscStopped_q, skip_q, waitCnt_q != 2'd0};
                default: rdMux = 32'h00000000;
            endcase
        end
    end

    // Read channel
    always @(posedge clk) begin
        if (!rstn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RSBX_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdMux;
            s_axi_rresp <= isMapped(s_axi_araddr) ? `RSBX_RESP_OKAY : `RSBX_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Write address and data, taken in either order
    always @(posedge clk) begin
        if (!rstn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                awHave_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end else if (doWrite) begin
                awHave_q <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wHave_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end else if (doWrite) begin
                wHave_q <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Response is held back until the instruction's cycles have run
    always @(posedge clk) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RSBX_RESP_OKAY;
            waitCnt_q <= 2'd0;
        end else if (doWrite) begin
            s_axi_bresp <= isMapped(awAddr_q) ? `RSBX_RESP_OKAY : `RSBX_RESP_SLVERR;
            if (isInstr && !oscStopped_q && !skip_q &&
                (opcode[11:4] == 8'h00 && opcode[3:2] == 2'b11 || opcode[11:8] == `RSBX_OP_LITRET)) begin
                waitCnt_q <= `RSBX_CYC_RETURN - 2'd1;
            end else begin
                s_axi_bvalid <= 1'b1;
            end
        end else if (waitCnt_q != 2'd0) begin
            waitCnt_q <= waitCnt_q - 2'd1;
            if (waitCnt_q == 2'd1) begin
                s_axi_bvalid <= 1'b1;
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Core state: bus writes and instruction execution
    always @(posedge clk) begin
        if (!rstn) begin
            w_q <= 8'h00;
            status_q <= `RSBX_RST_STATUS;
            ptr_q <= 8'h00;
            pc_q <= `RSBX_RST_PC;
            timer_q <= 8'h00;
            stackTop_q <= 12'h000;
            shW_q <= 8'h00;
            shStatus_q <= 8'h00;
            shPtr_q <= 8'h00;
            shPc_q <= 12'h000;
            skip_q <= 1'b0;
            wdtClear_q <= 1'b0;
            oscStopped_q <= 1'b0;
            for (i = 0; i < 32; i = i + 1) begin
                fileMem_q[i] <= 8'h00;
            end
        end else begin
            wdtClear_q <= 1'b0;
            if (doWrite && isInstr) begin
                // A sleeping core ignores instruction words until woken
                if (oscStopped_q) begin
                    pc_q <= pc_q;
                end else if (skip_q) begin
                    skip_q <= 1'b0;
                    pc_q <= pc_q + 12'h001;
                end else if (opcode == `RSBX_OP_IRETURN || opcode == `RSBX_OP_IRETURN_T) begin
                    if (opcode == `RSBX_OP_IRETURN_T) begin
                        timer_q <= timer_q + w_q;
                    end
                    w_q <= shW_q;
                    status_q <= (shStatus_q & ~`RSBX_ST_KEEP_MASK) | (status_q & `RSBX_ST_KEEP_MASK);
                    ptr_q <= shPtr_q;
                    pc_q <= shPc_q;
                end else if (opcode == `RSBX_OP_PRETURN) begin
                    pc_q <= stackTop_q;
                    status_q <= pagedStatus(status_q, stackTop_q);
                end else if (opcode == `RSBX_OP_RETURN) begin
                    pc_q <= stackTop_q;
                end else if (opcode[11:8] == `RSBX_OP_LITRET) begin
                    w_q <= opcode[7:0];
                    pc_q <= stackTop_q;
                end else if (opcode == `RSBX_OP_SLEEP) begin
                    wdtClear_q <= 1'b1;
                    oscStopped_q <= 1'b1;
                    status_q[`RSBX_ST_TMOUT] <= 1'b1;
                    status_q[`RSBX_ST_PDOWN] <= 1'b0;
                    pc_q <= pc_q + 12'h001;
                end else begin
                    pc_q <= pc_q + 12'h001;
                    skip_q <= aluSkip;
                    if (aluFileWe && fileIdx == `RSBX_F_STATUS) begin
                        status_q <= aluCarryWe ? {aluResult[7:1], aluCarry} : aluResult;
                    end else begin
                        if (aluCarryWe) begin
                            status_q[`RSBX_ST_CARRY] <= aluCarry;
                        end
                        if (aluFileWe) begin
                            if (fileIdx == `RSBX_F_TIMER) begin
                                timer_q <= aluResult;
                            end else if (fileIdx == `RSBX_F_PTR) begin
                                ptr_q <= aluResult;
                            end else begin
                                fileMem_q[fileIdx] <= aluResult;
                            end
                        end
                    end
                end
            end else if (doWrite && awAddr_q[`RSBX_FILE_SEL_BIT]) begin
                if (wStrb_q[0]) begin
                    fileMem_q[awAddr_q[6:2]] <= wData_q[7:0];
                end
            end else if (doWrite) begin
                case (awAddr_q)
                    `RSBX_ADDR_W: w_q <= wStrb_q[0] ? wData_q[7:0] : w_q;
                    `RSBX_ADDR_STATUS: status_q <= wStrb_q[0] ? wData_q[7:0] : status_q;
                    `RSBX_ADDR_FSRPTR: ptr_q <= wStrb_q[0] ? wData_q[7:0] : ptr_q;
                    `RSBX_ADDR_PC: pc_q <= applyStrb(pc_q, wData_q, wStrb_q);
                    `RSBX_ADDR_TIMER: timer_q <= wStrb_q[0] ? wData_q[7:0] : timer_q;
                    `RSBX_ADDR_STACK: stackTop_q <= applyStrb(stackTop_q, wData_q, wStrb_q);
                    `RSBX_ADDR_SHW: shW_q <= wStrb_q[0] ? wData_q[7:0] : shW_q;
                    `RSBX_ADDR_SHSTATUS: shStatus_q <= wStrb_q[0] ? wData_q[7:0] : shStatus_q;
                    `RSBX_ADDR_SHPTR: shPtr_q <= wStrb_q[0] ? wData_q[7:0] : shPtr_q;
                    `RSBX_ADDR_SHPC: shPc_q <= applyStrb(shPc_q, wData_q, wStrb_q);
                    `RSBX_ADDR_WAKE: oscStopped_q <= (wStrb_q[0] && wData_q[0]) ? 1'b0 : oscStopped_q;
                    default: skip_q <= skip_q;
                endcase
            end
        end
    end
endmodule // rsbx_exec

`default_nettype wire

/* testbench/rsbx_exec_sva.sv */
// Assertions on the executor's bus timing and sleep outputs
`timescale 1ns/10ps
`default_nettype none
module rsbx_exec_sva (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic wdtClear_q,
    input wire logic oscStopped_q
);
    logic wrTake;
    logic instrTake;
    logic isRet;
    logic wakeSeen_q;
    assign wrTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign instrTake = wrTake && s_axi_awaddr == 8'h00 && !oscStopped_q;
    // Opcodes 00c..00f and 8kk take two extra cycles
    assign isRet = s_axi_wdata[11:2] == 10'h003 || s_axi_wdata[11:8] == 4'h8;
    always @(posedge clk) begin
        if (!rstn) begin
            wakeSeen_q <= 1'b0;
        end else if (wrTake && s_axi_awaddr == 8'h30 && s_axi_wdata[0]) begin
            wakeSeen_q <= 1'b1;
        end else if (s_axi_bvalid && s_axi_bready) begin
            wakeSeen_q <= 1'b0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence oneCycle;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    sequence threeCycle;
        !s_axi_bvalid [*3] ##1 s_axi_bvalid;
    endsequence
    ret_latency_a: assert property (instrTake && isRet |=> threeCycle)
        else $error("return answered at the wrong cycle");
    single_latency_a: assert property (instrTake && !isRet |=> oneCycle)
        else $error("single cycle opcode answered at the wrong cycle");
    sleep_stop_a: assert property (instrTake && s_axi_wdata[11:0] == 12'h003 |=> ##1 (wdtClear_q && oscStopped_q))
        else $error("sleep did not clear watchdog and stop oscillator");
    wdt_pulse_a: assert property ($rose(wdtClear_q) |=> !wdtClear_q)
        else $error("watchdog clear longer than one cycle");
    wdt_cause_a: assert property ($rose(wdtClear_q) |-> $rose(oscStopped_q))
        else $error("watchdog clear without oscillator stop");
    osc_hold_a: assert property ($fell(oscStopped_q) |-> $past(wakeSeen_q))
        else $error("oscillator restarted without wake write");
    unmapped_resp_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h40
        |=> s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write accepted before response taken");
endmodule // rsbx_exec_sva
bind rsbx_exec rsbx_exec_sva u_rsbx_exec_sva (
    .clk(clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .wdtClear_q(wdtClear_q), .oscStopped_q(oscStopped_q)
);
`default_nettype wire

/* testbench/rsbx_exec_tb.sv */
// Self-checking bench for the return, skip and bit executor
`timescale 1ns/10ps
`default_nettype none
`include "rsbx_map.vh"
module rsbx_exec_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wdtClear_q, oscStopped_q;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [31:0] seed = 32'd64;
    logic [31:0] expQ [$];
    string nameQ [$];
    logic [1:0] rQ [$];
    logic [1:0] bQ [$];
    int n_errors = 0;
    int cmp_count = 0;
    int wdtCount = 0;
    int k;
    logic [4:0] f;
    logic [2:0] b;
    logic sk;
    logic [7:0] v, st, ptr, t, shW, shSt, shP, lit;
    logic [11:0] pc, s, shPc;
    logic [11:0] opTab [6] = '{12'h0, 12'h0, 12'h703, 12'h603, 12'h643, 12'h602};

    always #5 clk = ~clk;

    rsbx_exec #(.LARGE_PAGE(0)) u_rsbx_exec (
        .clk(clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .wdtClear_q(wdtClear_q), .oscStopped_q(oscStopped_q)
    );

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] fa(input logic [4:0] n);
        return {1'b1, n, 2'b00};
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `RSBX_RESP_OKAY);
        bit aw;
        bit w;
        bQ.push_back(er);
        aw = 0;
        w = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk);
            aw = aw | s_axi_awready;
            w = w | s_axi_wready;
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n, input logic [1:0] er = `RSBX_RESP_OKAY);
        expQ.push_back(e);
        nameQ.push_back(n);
        rQ.push_back(er);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask

    task automatic ex(input logic [11:0] o);
        wr(`RSBX_ADDR_INSTR, {20'h0, o});
        pc = pc + 12'h1;
    endtask

    task finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Results are matched in issue order, one note per response
    always @(posedge clk) begin
        if (wdtClear_q === 1'b1) wdtCount++;
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) chk("bresp", bQ.pop_front(), s_axi_bresp);
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            chk(nameQ.pop_front(), expQ.pop_front(), s_axi_rdata);
            chk("rresp", rQ.pop_front(), s_axi_rresp);
        end
    end

    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        finish_test();
    end

    initial begin
        pc = 12'h000;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd(`RSBX_ADDR_STATUS, 32'h18, "status");
        rd(`RSBX_ADDR_STATE, 32'h0, "state");
        $display("reset test done");
        for (int i = 0; i < 16; i++) begin
            f = 5'd5 + 5'(rnd() % 27);
            v = 8'(rnd());
            b = 3'(rnd());
            st = 8'h18 | 8'(rnd() & 32'h7);
            wr(`RSBX_ADDR_STATUS, {24'h0, st});
            wr(fa(f), {24'h0, v});
            k = i % 4;
            ex(k == 0 ? 12'h360 | f : k == 1 ? 12'h320 | f : k == 2 ? 12'h500 | {b, f} : 12'h503);
            rd(fa(f), k == 0 ? {v[6:0], st[0]} : k == 1 ? {st[0], v[7:1]} : k == 2 ? v | (8'h1 << b) : v, "file");
            if (k != 2) st[0] = k == 0 ? v[7] : k == 1 ? v[0] : 1'b1;
            rd(`RSBX_ADDR_STATUS, {24'h0, st}, "status");
            rd(`RSBX_ADDR_PC, {20'h0, pc}, "pc");
        end
        $display("rotate and bit test done");
        for (int i = 0; i < 18; i++) begin
            f = 5'd6 + 5'(rnd() % 26);
            v = 8'(rnd());
            b = 3'(rnd());
            st = 8'h18 | 8'(rnd() & 32'h7);
            wr(`RSBX_ADDR_STATUS, {24'h0, st});
            wr(fa(f), {24'h0, v});
            wr(fa(5'd5), 32'h0);
            k = i % 6;
            sk = k == 0 ? v[b] : k == 1 ? !v[b] : k == 2 ? st[0] : k == 3 ? !st[0] : k == 4 ? !st[2] : 1'b1;
            ex(k == 0 ? 12'h700 | {b, f} : k == 1 ? 12'h600 | {b, f} : opTab[k]);
            ex(12'h505);
            ex(12'h525);
            rd(fa(5'd5), {30'h0, 1'b1, !sk}, "skipped word");
            rd(`RSBX_ADDR_STATUS, {24'h0, st}, "status");
            rd(`RSBX_ADDR_PC, {20'h0, pc}, "pc");
        end
        $display("skip test done");
        for (int i = 0; i < 10; i++) begin
            s = 12'(rnd());
            v = 8'(rnd());
            t = 8'(rnd());
            lit = 8'(rnd());
            ptr = 8'(rnd());
            shW = 8'(rnd());
            shP = 8'(rnd());
            shPc = 12'(rnd());
            // Shadow holds opposite timeout and power-down bits so a wrong restore shows
            shSt = 8'(rnd()) & 8'he7;
            st = 8'h18 | 8'(rnd() & 32'h7);
            wr(`RSBX_ADDR_STACK, {20'h0, s});
            wr(`RSBX_ADDR_W, {24'h0, v});
            wr(`RSBX_ADDR_TIMER, {24'h0, t});
            wr(`RSBX_ADDR_FSRPTR, {24'h0, ptr});
            wr(`RSBX_ADDR_STATUS, {24'h0, st});
            wr(`RSBX_ADDR_SHW, {24'h0, shW});
            wr(`RSBX_ADDR_SHSTATUS, {24'h0, shSt});
            wr(`RSBX_ADDR_SHPTR, {24'h0, shP});
            wr(`RSBX_ADDR_SHPC, {20'h0, shPc});
            k = i % 5;
            ex(k == 4 ? {4'h8, lit} : 12'h00c + 12'(k));
            if (k == 3) t = t + v;
            if (k == 1) st[6:5] = s[10:9];
            if (k == 2 || k == 3) st = (shSt & 8'he7) | 8'h18;
            if (k == 2 || k == 3) v = shW;
            if (k == 2 || k == 3) ptr = shP;
            if (k == 4) v = lit;
            pc = (k == 2 || k == 3) ? shPc : s;
            rd(`RSBX_ADDR_PC, {20'h0, pc}, "pc");
            rd(`RSBX_ADDR_W, {24'h0, v}, "w");
            rd(`RSBX_ADDR_STATUS, {24'h0, st}, "status");
            rd(`RSBX_ADDR_FSRPTR, {24'h0, ptr}, "pointer");
            rd(`RSBX_ADDR_TIMER, {24'h0, t}, "timer");
        end
        $display("return test done");
        wr(`RSBX_ADDR_STATUS, 32'h18);
        ex(`RSBX_OP_SLEEP);
        rd(`RSBX_ADDR_STATUS, 32'h10, "status");
        rd(`RSBX_ADDR_STATE, 32'h4, "state");
        wr(`RSBX_ADDR_INSTR, {20'h0, `RSBX_OP_FORCE_C});
        rd(`RSBX_ADDR_STATUS, 32'h10, "status");
        rd(`RSBX_ADDR_PC, {20'h0, pc}, "pc");
        wr(`RSBX_ADDR_WAKE, 32'h1);
        rd(`RSBX_ADDR_STATE, 32'h0, "state");
        chk("watchdog pulses", 32'h1, wdtCount);
        $display("sleep test done");
        rd(8'h40, 32'h0, "unmapped", `RSBX_RESP_SLVERR);
        rd(8'h34, 32'h0, "unmapped", `RSBX_RESP_SLVERR);
        wr(8'h40, 32'h5a, `RSBX_RESP_SLVERR);
        $display("unmapped test done");
        finish_test();
    end
endmodule // rsbx_exec_tb
`default_nettype wire
